// [verilog/hcc_pkg.sv]
// Purpose: Constants for the host controller control register bank.
// Assumes: AXI4-Lite with 32-bit data, byte addresses as printed.
// Notes:   Soft reset length and clock period are held here too.
package hcc_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_VENDOR      = 8'h40;
  localparam logic [7:0]  OFF_CTRL_SET    = 8'h50;
  localparam logic [7:0]  OFF_CTRL_CLR    = 8'h54;
  // Identification value is arbitrary.
  localparam logic [31:0] VENDOR_IDENTIFIER_VAL   = 32'h3c5a_96e1;
  localparam int          BIT_SWAP_DIS    = 30;
  localparam int          BIT_CFG_PERMIT  = 23;
  localparam int          BIT_ENH_ON      = 22;
  localparam int          BIT_LINK_PWR    = 19;
  localparam int          BIT_POST_ON     = 18;
  localparam int          BIT_ATTACH      = 17;
  localparam int          BIT_SRST        = 16;
  // Bits that software may set through the set address, apart from the soft reset bit.
  localparam logic [31:0] SETTABLE_MASK   = 32'h404e_0000;
  // Bits that exist at all; everything else reads zero.
  localparam logic [31:0] IMPL_MASK       = 32'h40cf_0000;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam int          SRST_TIME_NS    = 400;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          SRST_CYCLES     =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SRST_CNT_INIT   = 4'(SRST_CYCLES);
endpackage : hcc_pkg

// [verilog/hcc_regs.sv]
// Purpose: Vendor identification and set/clear control register.
// Assumes: One clock, synchronous active-low reset, AXI4-Lite slave.
// Notes:   Soft reset runs a fixed count, then drops by itself.
//
// Functional notes
// - Vendor register is read-only, ignores writes, returns fixed value.
// - Control reached by set address and clear address; ones act.
// - Reserved control bits read zero and never change.
// - Swap disable bit steers byte swapping of DMA and physical data.
// - Configuration permit loads from EEPROM; software may only clear it.
// - Link power status bit gates link to physical-layer communication.
// - Posted writes accepted only while write posting bit is one.
// - Attach bit is cleared by hardware and soft reset.
// - With attach zero, device is disconnected at once from the bus.
// - Soft reset clears internal state, flushes FIFOs, resets registers.
// - Soft reset leaves host-bus configuration registers alone.
// - Soft reset bit reads one while busy, clears itself when done.
`timescale 1ns/1ps
module hcc_regs
  import hcc_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Strap from serial EEPROM loader
  input  wire logic              eeprom_cfg_permit,
  input  wire logic              eeprom_load,
  // Link side
  input  wire logic              posted_write_req,
  output logic                   posted_write_ack,
  output logic                   data_swap_on,
  output logic                   phy_comm_allow,
  output logic                   bus_attached,
  output logic                   enhanced_on,
  output logic                   core_flush
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]       ctrl_ff;
  logic [31:0]       nxt_ctrl;
  logic [3:0]        srst_cnt_ff;
  logic [3:0]        nxt_srst_cnt;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              aw_have_ff;
  logic              w_have_ff;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order.
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire aw_now    = aw_have_ff || aw_take;
  wire w_now     = w_have_ff || w_take;
  wire do_write  = aw_now && w_now && !s_axi_bvalid;
  wire [ADDR_W-1:0] wa = aw_have_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd  = (w_have_ff ? wdata_ff : s_axi_wdata)
                    & strb_mask(w_have_ff ? wstrb_ff : s_axi_wstrb);
  wire wr_set    = do_write && (wa == OFF_CTRL_SET);
  wire wr_clr    = do_write && (wa == OFF_CTRL_CLR);
  wire wr_ok     = wr_set || wr_clr || (wa == OFF_VENDOR);
  wire srst_busy = (srst_cnt_ff != 4'h0);
  wire srst_req  = wr_set && wd[BIT_SRST];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= '0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_have_ff    <= aw_now && !do_write;
      w_have_ff     <= w_now && !do_write;
      s_axi_awready <= !aw_now && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_now && !s_axi_wready && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register update. Soft reset wins over everything else in the
  // cycle it starts, so a write paired with it cannot leave stale state.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_set) begin
      nxt_ctrl = ctrl_ff | (wd & SETTABLE_MASK);
    end
    if (wr_clr) begin
      nxt_ctrl = ctrl_ff & ~(wd & IMPL_MASK & ~(32'h1 << BIT_SRST));
    end
    if (eeprom_load) begin
      nxt_ctrl[BIT_CFG_PERMIT] = eeprom_cfg_permit;
    end
    if (srst_req || srst_busy) begin
      // Permit is a strap image, kept across soft reset like config space.
      nxt_ctrl = (CTRL_RESET & ~(32'h1 << BIT_CFG_PERMIT))
               | (ctrl_ff & (32'h1 << BIT_CFG_PERMIT));
    end
    nxt_ctrl[BIT_SRST] = srst_req || (srst_cnt_ff > 4'h1);
    nxt_ctrl = nxt_ctrl & IMPL_MASK;
  end

  always_comb begin
    nxt_srst_cnt = srst_busy ? srst_cnt_ff - 4'h1 : 4'h0;
    if (srst_req) begin
      nxt_srst_cnt = SRST_CNT_INIT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff     <= CTRL_RESET;
      srst_cnt_ff <= 4'h0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      srst_cnt_ff <= nxt_srst_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, answered the cycle after arvalid meets arready.
  wire [31:0] rd_val = (s_axi_araddr == OFF_VENDOR) ? VENDOR_IDENTIFIER_VAL
                     : ctrl_ff;
  wire rd_hit = (s_axi_araddr == OFF_VENDOR)
             || (s_axi_araddr == OFF_CTRL_SET)
             || (s_axi_araddr == OFF_CTRL_CLR);
  wire ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_val : 32'h0;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link-facing controls. Software ordering of enhancement and posting
  // changes is trusted; the device does not police it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_swap_on     <= 1'b1;
      phy_comm_allow   <= 1'b0;
      bus_attached     <= 1'b0;
      enhanced_on      <= 1'b0;
      core_flush       <= 1'b0;
      posted_write_ack <= 1'b0;
    end else begin
      data_swap_on     <= !nxt_ctrl[BIT_SWAP_DIS];
      phy_comm_allow   <= nxt_ctrl[BIT_LINK_PWR];
      bus_attached     <= nxt_ctrl[BIT_ATTACH];
      enhanced_on      <= nxt_ctrl[BIT_ENH_ON] && nxt_ctrl[BIT_CFG_PERMIT]
                          && nxt_ctrl[BIT_ATTACH];
      core_flush       <= nxt_ctrl[BIT_SRST];
      posted_write_ack <= posted_write_req && ctrl_ff[BIT_POST_ON]
                          && ctrl_ff[BIT_ATTACH];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_vendor_const;
    @(posedge aclk) disable iff (!aresetn)
      ar_take && (s_axi_araddr == OFF_VENDOR) |=>
        s_axi_rvalid && (s_axi_rdata == VENDOR_IDENTIFIER_VAL);
  endproperty
  a_vendor_const: assert property (p_vendor_const)
    else $error("Vendor read returned wrong value.");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_ff & ~IMPL_MASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved control bit is set.");

  property p_set_works;
    @(posedge aclk) disable iff (!aresetn)
      wr_set && wd[BIT_LINK_PWR] && !srst_req && !srst_busy
        |=> ctrl_ff[BIT_LINK_PWR];
  endproperty
  a_set_works: assert property (p_set_works)
    else $error("Set address did not set the bit.");

  property p_clr_works;
    @(posedge aclk) disable iff (!aresetn)
      wr_clr && wd[BIT_POST_ON] |=> !ctrl_ff[BIT_POST_ON];
  endproperty
  a_clr_works: assert property (p_clr_works)
    else $error("Clear address did not clear the bit.");

  property p_permit_no_set;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_ff[BIT_CFG_PERMIT] && !eeprom_load |=> !ctrl_ff[BIT_CFG_PERMIT];
  endproperty
  a_permit_no_set: assert property (p_permit_no_set)
    else $error("Permit bit rose without the strap.");

  property p_attach_srst;
    @(posedge aclk) disable iff (!aresetn)
      srst_req |=> !ctrl_ff[BIT_ATTACH] ##1 !bus_attached;
  endproperty
  a_attach_srst: assert property (p_attach_srst)
    else $error("Attach survived soft reset.");

  property p_srst_len;
    @(posedge aclk) disable iff (!aresetn)
      srst_req |=> ctrl_ff[BIT_SRST] [*8] ##1 !ctrl_ff[BIT_SRST];
  endproperty
  a_srst_len: assert property (p_srst_len)
    else $error("Soft reset bit length is wrong.");

  property p_post_gate;
    @(posedge aclk) disable iff (!aresetn)
      posted_write_ack |-> $past(ctrl_ff[BIT_POST_ON]);
  endproperty
  a_post_gate: assert property (p_post_gate)
    else $error("Posted write accepted while disabled.");

  property p_power_follow;
    @(posedge aclk) disable iff (!aresetn)
      ##1 phy_comm_allow == ctrl_ff[BIT_LINK_PWR];
  endproperty
  a_power_follow: assert property (p_power_follow)
    else $error("Link power gate does not follow the bit.");

  property p_swap_follow;
    @(posedge aclk) disable iff (!aresetn)
      data_swap_on == !ctrl_ff[BIT_SWAP_DIS];
  endproperty
  a_swap_follow: assert property (p_swap_follow)
    else $error("Swap control does not follow the bit.");

  property p_enh_gate;
    @(posedge aclk) disable iff (!aresetn)
      enhanced_on |-> ctrl_ff[BIT_ENH_ON] && ctrl_ff[BIT_CFG_PERMIT]
        && ctrl_ff[BIT_ATTACH];
  endproperty
  a_enh_gate: assert property (p_enh_gate)
    else $error("Enhancements on without permit and attach.");

  property p_srst_clears;
    @(posedge aclk) disable iff (!aresetn)
      srst_req |=> !ctrl_ff[BIT_SWAP_DIS] && !ctrl_ff[BIT_ENH_ON]
        && !ctrl_ff[BIT_LINK_PWR] && !ctrl_ff[BIT_POST_ON];
  endproperty
  a_srst_clears: assert property (p_srst_clears)
    else $error("Soft reset left a control bit set.");

  property p_flush_follow;
    @(posedge aclk) disable iff (!aresetn)
      core_flush == ctrl_ff[BIT_SRST];
  endproperty
  a_flush_follow: assert property (p_flush_follow)
    else $error("Flush output does not follow the soft reset bit.");

endmodule : hcc_regs

// [tb/testbench.sv]
// Purpose: Self-checking bench for the control register bank.
// Assumes: AXI4-Lite master tasks, one request at a time.
// Notes:   Assertions live in the design; this bench drives ports and checks responses and outputs.
`timescale 1ns/1ps
module testbench import hcc_pkg::*;;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, eeprom_load;
  logic        eeprom_cfg_permit, posted_write_req, posted_write_ack;
  logic        data_swap_on, phy_comm_allow, bus_attached, enhanced_on;
  logic        core_flush;
  int          n_errors, n_checks;
  //////////////////////////////////////////////////////////////////////////
  hcc_regs hcc_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .eeprom_cfg_permit(eeprom_cfg_permit),
    .eeprom_load(eeprom_load), .posted_write_req(posted_write_req),
    .posted_write_ack(posted_write_ack), .data_swap_on(data_swap_on),
    .phy_comm_allow(phy_comm_allow), .bus_attached(bus_attached),
    .enhanced_on(enhanced_on), .core_flush(core_flush));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Each wait is bounded so a dead handshake ends the run cleanly.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1;
        s_axi_bready <= 1'b0;
        check("bresp", 32'(s_axi_bresp), 32'(er));
      end
    end
    if (!done) begin
      n_errors++;
      finish_test();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, ed);
        check("rresp", 32'(s_axi_rresp), 32'(er));
      end
    end
    if (!done) begin
      n_errors++;
      finish_test();
    end
  endtask : rd
  task automatic strap(input logic v);
    @(posedge aclk);
    eeprom_cfg_permit <= v;
    eeprom_load       <= 1'b1;
    @(posedge aclk);
    eeprom_load <= 1'b0;
  endtask : strap
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_vendor();
    rd(OFF_VENDOR, VENDOR_IDENTIFIER_VAL, RESP_OKAY);
    rd(OFF_CTRL_SET, CTRL_RESET, RESP_OKAY);
    rd(OFF_CTRL_CLR, CTRL_RESET, RESP_OKAY);
    check("data_swap_on", data_swap_on, 1);
    wr(OFF_VENDOR, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_VENDOR, VENDOR_IDENTIFIER_VAL, RESP_OKAY);
    wr(8'h44, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h44, 32'h0000_0000, RESP_SLVERR);
    rd(OFF_CTRL_SET, CTRL_RESET, RESP_OKAY);
  endtask : t_reset_and_vendor
  // Driver ordering is kept here: attach last, posting only while detached.
  task automatic t_set_clear();
    wr(OFF_CTRL_SET, 32'hff3c_ffff, RESP_OKAY);
    rd(OFF_CTRL_SET, 32'h400c_0000, RESP_OKAY);
    rd(OFF_CTRL_CLR, 32'h400c_0000, RESP_OKAY);
    check("data_swap_on", data_swap_on, 32'h0);
    check("phy_comm_allow", phy_comm_allow, 32'h1);
    check("bus_attached", bus_attached, 32'h0);
    check("core_flush", core_flush, 32'h0);
    wr(OFF_CTRL_SET, 32'h0002_0000, RESP_OKAY);
    check("bus_attached", bus_attached, 32'h1);
    wr(OFF_CTRL_CLR, 32'hbf33_ffff, RESP_OKAY);
    rd(OFF_CTRL_SET, 32'h400c_0000, RESP_OKAY);
    check("bus_attached", bus_attached, 32'h0);
    wr(OFF_CTRL_CLR, 32'h0004_0000, RESP_OKAY);
    rd(OFF_CTRL_CLR, 32'h4008_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hb;
    wr(OFF_CTRL_SET, 32'h0004_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFF_CTRL_SET, 32'h4008_0000, RESP_OKAY);
    wr(OFF_CTRL_SET, 32'h0004_0000, RESP_OKAY);
    wr(OFF_CTRL_SET, 32'h0002_0000, RESP_OKAY);
  endtask : t_set_clear
  task automatic t_permit();
    strap(1'b1);
    rd(OFF_CTRL_SET, 32'h408e_0000, RESP_OKAY);
    check("enhanced_on", enhanced_on, 32'h0);
    wr(OFF_CTRL_SET, 32'h0040_0000, RESP_OKAY);
    check("enhanced_on", enhanced_on, 32'h1);
    wr(OFF_CTRL_CLR, 32'h0080_0000, RESP_OKAY);
    check("enhanced_on", enhanced_on, 32'h0);
    wr(OFF_CTRL_SET, 32'h0080_0000, RESP_OKAY);
    rd(OFF_CTRL_SET, 32'h404e_0000, RESP_OKAY);
    strap(1'b1);
    rd(OFF_CTRL_CLR, 32'h40ce_0000, RESP_OKAY);
  endtask : t_permit
  task automatic t_posted();
    @(posedge aclk);
    posted_write_req <= 1'b1;
    repeat (3) @(posedge aclk);
    check("posted_write_ack", posted_write_ack, 32'h1);
    wr(OFF_CTRL_CLR, 32'h0002_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("posted_write_ack", posted_write_ack, 32'h0);
    check("bus_attached", bus_attached, 32'h0);
    wr(OFF_CTRL_CLR, 32'h0004_0000, RESP_OKAY);
    wr(OFF_CTRL_SET, 32'h0002_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("posted_write_ack", posted_write_ack, 32'h0);
    wr(OFF_CTRL_CLR, 32'h0002_0000, RESP_OKAY);
    wr(OFF_CTRL_SET, 32'h0004_0000, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("posted_write_ack", posted_write_ack, 32'h0);
    posted_write_req <= 1'b0;
  endtask : t_posted
  task automatic t_soft_reset();
    wr(OFF_CTRL_SET, 32'h0002_0000, RESP_OKAY);
    check("bus_attached", bus_attached, 32'h1);
    wr(OFF_CTRL_SET, 32'h0001_0000, RESP_OKAY);
    check("core_flush", core_flush, 32'h1);
    rd(OFF_CTRL_SET, 32'h0081_0000, RESP_OKAY);
    repeat (12) @(posedge aclk);
    rd(OFF_CTRL_CLR, 32'h0080_0000, RESP_OKAY);
    check("data_swap_on", data_swap_on, 32'h1);
    check("bus_attached", bus_attached, 32'h0);
    check("phy_comm_allow", phy_comm_allow, 32'h0);
    check("core_flush", core_flush, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CTRL_SET, CTRL_RESET, RESP_OKAY);
  endtask : t_soft_reset
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, eeprom_load, eeprom_cfg_permit} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    posted_write_req = 1'b0;
    s_axi_wstrb      = 4'hf;
    n_errors         = 0;
    n_checks         = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_and_vendor();
    t_set_clear();
    t_permit();
    t_posted();
    t_soft_reset();
    finish_test();
  end
endmodule : testbench
